// File: shared/dsf_defines.svh
// register layout, address byte layout and timing counts of the serial port
// assumes a 250 MHz system clock on both ends
`ifndef DSF_DEFINES_SVH
`define DSF_DEFINES_SVH

// ==========================================================
// register file
`define DSF_NREG 32
`define DSF_REG_GCON 5'h00
`define DSF_REG_DMOD 5'h01
`define DSF_REG_FDEV 5'h02
`define DSF_REG_BRS 5'h03
`define DSF_REG_RST 8'h00
`define DSF_GCON_RST 8'h20
`define DSF_DMOD_RST 8'h04
`define DSF_FDEV_RST 8'h03
`define DSF_BRS_RST 8'h07

// ==========================================================
// fields
`define DSF_MODE_HI 7
`define DSF_MODE_LO 5
`define DSF_MODE_RX 3'h3
`define DSF_MODE_TX 3'h4
`define DSF_OOK_BIT 7
`define DSF_DM_HI 3
`define DSF_DM_LO 2
`define DSF_DM_BUF 2'h1
`define DSF_DM_PKT 2'h2
`define DSF_DM_CONT 2'h0
// address byte: bit 7 read flag, bits 4:0 index
`define DSF_RD_BIT 7
`define DSF_IDX_HI 4

// ==========================================================
// fifo and bit timing
`define DSF_FIFO_DEPTH 16
`define DSF_PTR_W 5
`define DSF_BIT_UNIT 24'h00_0032
`define DSF_CLK_MHZ 250
`define DSF_CFG_SCK_MHZ 6
`define DSF_DAT_SCK_MHZ 1
`define DSF_CFG_HALF 8'((`DSF_CLK_MHZ + 2 * `DSF_CFG_SCK_MHZ - 1) / (2 * `DSF_CFG_SCK_MHZ))
`define DSF_DAT_HALF 8'((`DSF_CLK_MHZ + 2 * `DSF_DAT_SCK_MHZ - 1) / (2 * `DSF_DAT_SCK_MHZ))

`endif

// File: shared/dsf_pkg.sv
// types shared by both ends of the serial port
// assumes nothing beyond a systemverilog compiler
package dsf_pkg;
   typedef enum logic [1:0] {cmd_cfg_wr, cmd_cfg_rd, cmd_fifo_wr, cmd_fifo_rd} dsf_cmd_t;
   typedef enum logic [1:0] {port_none, port_cfg, port_fifo} dsf_port_t;
   typedef enum logic [2:0] {hs_idle, hs_low, hs_high, hs_tail, hs_gap} dsf_hst_t;
endpackage

// File: shared/dsf_link_if.sv
// serial link between host and transceiver: clock, data in/out, two selects
// assumes the bench resolves the output wire from sdo and sdo_oe
interface dsf_link_if;
   logic sck;
   logic sdi;
   logic config_port_select_n;
   logic fifo_port_select_n;
   logic sdo;
   logic sdo_oe;
   modport device (
      input sck, sdi, config_port_select_n, fifo_port_select_n,
      output sdo, sdo_oe
   );
   modport host (
      output sck, sdi, config_port_select_n, fifo_port_select_n,
      input sdo, sdo_oe
   );
endinterface

// File: logic/dsf_device.sv
// transceiver end: config and fifo sub-ports, fifo, byte serializer to radio
// assumes the link is asynchronous to clk_in and sampled through two flops
// What this block does
// - config select wins; fifo only if config high
// - mode 0,0; sck idles low
// - master holds select low whole transfer
// - sdo driven only while a select low
// - sdo tri-stateable, keeps last level
// - eight bits per byte per select
// - sample sdi on sck rising edge
// - change sdo on sck falling edge
// - most significant bit first always
// - sck at most 6 or 1 MHz
// - config writes commit at select rise
// - alternating address/value bytes, several writes
// - chained reads alternate address and value
// - config port works in every mode
// - fifo port only in buffered/packet
// - fifo write pushed at select rise
// - fifo reads preferably toggle select
// - fifo is byte wide, byte access
// - transmit serializer sends fifo bytes msb first
// - receive serializer collects bytes into fifo
// - fsk one high deviation; ook one pa on
// - power-on defaults, kept through sleep
// - continuous mode bypasses fifo via data pin
`include "dsf_defines.svh"
module dsf_device (
   // clock and reset
   input wire logic clk_in,
   input wire logic rst_b_in,
   // serial link
   dsf_link_if.device link,
   // radio side
   input wire logic demod_bit_in,
   input wire logic data_pin_in,
   output logic data_pin_out,
   output logic data_pin_oe_out,
   output logic mod_freq_hi_out,
   output logic pa_on_out,
   // status
   output logic [2:0] op_mode_out,
   output logic [7:0] freq_deviation_value_out,
   output logic [`DSF_PTR_W-1:0] fifo_level_out
);
   // ==========================================================
   // input synchronisers
   logic [5:0] s1_r, s2_r;
   always_ff @(posedge clk_in or negedge rst_b_in) begin
      if (!rst_b_in) begin
         {s1_r, s2_r} <= 12'hc30; // idle link levels, no false sck edge
      end else begin
         s1_r <= {link.config_port_select_n, link.fifo_port_select_n, link.sck, link.sdi,
                  demod_bit_in, data_pin_in};
         s2_r <= s1_r;
      end
   end
   logic cfg_n_s, fifo_n_s, sck_s, sdi_s, demod_s, data_s;
   assign {cfg_n_s, fifo_n_s, sck_s, sdi_s, demod_s, data_s} = s2_r;
   // ==========================================================
   // registers, mode decode, port select
   logic [7:0] cfg_r [`DSF_NREG];
   logic [7:0] stage_r [`DSF_NREG];
   logic [`DSF_NREG-1:0] stage_v_r;
   logic [2:0] mode;
   logic [1:0] dm;
   logic fifo_mode, cont_mode, rd_mode, sck_p_r, sel_p_r, cfg_p_r, fifo_p_r, byte_done;
   dsf_pkg::dsf_port_t port;
   assign mode = cfg_r[`DSF_REG_GCON][`DSF_MODE_HI:`DSF_MODE_LO];
   assign dm = cfg_r[`DSF_REG_DMOD][`DSF_DM_HI:`DSF_DM_LO];
   assign fifo_mode = (dm == `DSF_DM_BUF) || (dm == `DSF_DM_PKT);
   assign cont_mode = (dm == `DSF_DM_CONT);
   assign rd_mode = (mode == `DSF_MODE_RX);
   always_comb begin
      port = dsf_pkg::port_none;
      if (!cfg_n_s)
         port = dsf_pkg::port_cfg;
      else if (!fifo_n_s && fifo_mode)
         port = dsf_pkg::port_fifo;
   end
   logic cfg_sel, fifo_sel, sel_any, sck_rise, sck_fall, sel_start, cfg_end, fifo_end;
   assign cfg_sel = (port == dsf_pkg::port_cfg);
   assign fifo_sel = (port == dsf_pkg::port_fifo);
   assign sel_any = cfg_sel | fifo_sel;
   assign sck_rise = sck_s & ~sck_p_r;
   assign sck_fall = ~sck_s & sck_p_r;
   assign sel_start = sel_any & ~sel_p_r;
   assign cfg_end = cfg_p_r & ~cfg_sel;
   assign fifo_end = fifo_p_r & ~fifo_sel;
   always_ff @(posedge clk_in or negedge rst_b_in) begin
      if (!rst_b_in)
         {sck_p_r, sel_p_r, cfg_p_r, fifo_p_r} <= 4'h0;
      else
         {sck_p_r, sel_p_r, cfg_p_r, fifo_p_r} <= {sck_s, sel_any, cfg_sel, fifo_sel};
   end
   // ==========================================================
   // receive shifter
   logic [2:0] bit_cnt_r;
   logic [6:0] rx_sh_r;
   logic [7:0] rx_byte, wr_byte_r;
   assign byte_done = sel_any & sck_rise & (bit_cnt_r == 3'h7);
   assign rx_byte = {rx_sh_r, sdi_s};
   always_ff @(posedge clk_in or negedge rst_b_in) begin
      if (!rst_b_in) begin
         {bit_cnt_r, rx_sh_r} <= 10'h000;
      end else if (!sel_any) begin
         bit_cnt_r <= 3'h0;
      end else if (sck_rise) begin
         rx_sh_r <= {rx_sh_r[5:0], sdi_s};
         bit_cnt_r <= bit_cnt_r + 3'h1;
      end
   end
   // ==========================================================
   // config sub-port: address/value alternation and staged writes
   logic val_phase_r, rd_r, got_byte_r, sdo_r;
   logic [`DSF_IDX_HI:0] addr_r;
   always_ff @(posedge clk_in or negedge rst_b_in) begin
      if (!rst_b_in) begin
         {val_phase_r, rd_r, addr_r} <= 7'h00;
      end else if (!cfg_sel) begin
         val_phase_r <= 1'b0;
      end else if (byte_done) begin
         val_phase_r <= ~val_phase_r;
         if (!val_phase_r) begin
            addr_r <= rx_byte[`DSF_IDX_HI:0];
            rd_r <= rx_byte[`DSF_RD_BIT];
         end
      end
   end
   always_ff @(posedge clk_in or negedge rst_b_in) begin
      if (!rst_b_in) begin
         stage_v_r <= '0;
         for (int i = 0; i < `DSF_NREG; i++) begin
            stage_r[i] <= `DSF_REG_RST;
            cfg_r[i] <= `DSF_REG_RST;
         end
         cfg_r[`DSF_REG_GCON] <= `DSF_GCON_RST;
         cfg_r[`DSF_REG_DMOD] <= `DSF_DMOD_RST;
         cfg_r[`DSF_REG_FDEV] <= `DSF_FDEV_RST;
         cfg_r[`DSF_REG_BRS] <= `DSF_BRS_RST;
      end else if (cfg_end) begin
         for (int i = 0; i < `DSF_NREG; i++) begin
            if (stage_v_r[i])
               cfg_r[i] <= stage_r[i];
         end
         stage_v_r <= '0;
      end else if (cfg_sel && byte_done && val_phase_r && !rd_r) begin
         stage_r[addr_r] <= rx_byte;
         stage_v_r[addr_r] <= 1'b1;
      end
   end
   // ==========================================================
   // fifo
   logic [7:0] mem_r [`DSF_FIFO_DEPTH];
   logic [`DSF_PTR_W-1:0] wr_r, rd_ptr_r, level;
   logic full, empty, push, pop, spi_push, spi_pop, ser_push, ser_pop;
   logic [7:0] push_byte, ser_byte, head, next_head;
   assign level = wr_r - rd_ptr_r;
   assign full = (level == `DSF_PTR_W'(`DSF_FIFO_DEPTH));
   assign empty = (level == '0);
   assign head = mem_r[rd_ptr_r[`DSF_PTR_W-2:0]];
   assign next_head = mem_r[rd_ptr_r[`DSF_PTR_W-2:0] + 4'h1];
   assign push = (spi_push | ser_push) & ~full;
   assign pop = (spi_pop | ser_pop) & ~empty;
   assign push_byte = spi_push ? wr_byte_r : ser_byte;
   always_ff @(posedge clk_in or negedge rst_b_in) begin
      if (!rst_b_in) begin
         {wr_r, rd_ptr_r} <= 10'h000;
      end else begin
         if (push) begin
            mem_r[wr_r[`DSF_PTR_W-2:0]] <= push_byte;
            wr_r <= wr_r + `DSF_PTR_W'(1);
         end
         if (pop)
            rd_ptr_r <= rd_ptr_r + `DSF_PTR_W'(1);
      end
   end
   // ==========================================================
   // fifo sub-port
   assign spi_push = fifo_end & got_byte_r & ~rd_mode;
   assign spi_pop = fifo_sel & rd_mode & byte_done;
   always_ff @(posedge clk_in or negedge rst_b_in) begin
      if (!rst_b_in) begin
         {wr_byte_r, got_byte_r} <= 9'h000;
      end else if (sel_start) begin
         got_byte_r <= 1'b0;
      end else if (fifo_sel && byte_done && !rd_mode) begin
         wr_byte_r <= rx_byte;
         got_byte_r <= 1'b1;
      end
   end
   // ==========================================================
   // serial output, bus-hold on sdo
   logic [7:0] tx_sh_r, first;
   assign first = (fifo_sel && rd_mode && !empty) ? head : 8'h00;
   always_ff @(posedge clk_in or negedge rst_b_in) begin
      if (!rst_b_in) begin
         {tx_sh_r, sdo_r} <= 9'h000;
      end else if (sel_start) begin
         sdo_r <= first[7];
         tx_sh_r <= {first[6:0], 1'b0};
      end else if (cfg_sel && byte_done && !val_phase_r) begin
         tx_sh_r <= rx_byte[`DSF_RD_BIT] ? cfg_r[rx_byte[`DSF_IDX_HI:0]] : 8'h00;
      end else if (spi_pop) begin
         tx_sh_r <= (level > `DSF_PTR_W'(1)) ? next_head : 8'h00;
      end else if (sel_any && sck_fall) begin
         sdo_r <= tx_sh_r[7];
         tx_sh_r <= {tx_sh_r[6:0], 1'b0};
      end
   end
   assign link.sdo = sdo_r;
   assign link.sdo_oe = sel_any;
   // ==========================================================
   // byte serializer between fifo and radio
   logic [23:0] bt_cnt_r, bt_lim;
   logic tick, tx_on, rx_on, tx_bit_r;
   logic [7:0] byte_serializer_r;
   logic [3:0] ser_cnt_r;
   assign bt_lim = (24'(cfg_r[`DSF_REG_BRS]) + 24'h00_0001) * `DSF_BIT_UNIT;
   assign tick = (bt_cnt_r >= bt_lim - 24'h00_0001);
   assign tx_on = fifo_mode & (mode == `DSF_MODE_TX);
   assign rx_on = fifo_mode & rd_mode;
   assign ser_pop = tx_on & tick & (ser_cnt_r == 4'h0) & ~empty;
   assign ser_push = rx_on & tick & (ser_cnt_r == 4'h7);
   assign ser_byte = {byte_serializer_r[6:0], demod_s};
   always_ff @(posedge clk_in or negedge rst_b_in) begin
      if (!rst_b_in)
         bt_cnt_r <= 24'h00_0000;
      else
         bt_cnt_r <= tick ? 24'h00_0000 : bt_cnt_r + 24'h00_0001;
   end
   always_ff @(posedge clk_in or negedge rst_b_in) begin
      if (!rst_b_in) begin
         {byte_serializer_r, ser_cnt_r, tx_bit_r} <= 13'h0000;
      end else if (!tx_on && !rx_on) begin
         ser_cnt_r <= 4'h0;
      end else if (tick && tx_on) begin
         if (ser_cnt_r != 4'h0) begin
            tx_bit_r <= byte_serializer_r[7];
            byte_serializer_r <= {byte_serializer_r[6:0], 1'b0};
            ser_cnt_r <= ser_cnt_r - 4'h1;
         end else if (!empty) begin
            tx_bit_r <= head[7];
            byte_serializer_r <= {head[6:0], 1'b0};
            ser_cnt_r <= 4'h7;
         end
      end else if (tick) begin
         byte_serializer_r <= ser_byte;
         ser_cnt_r <= (ser_cnt_r == 4'h7) ? 4'h0 : ser_cnt_r + 4'h1;
      end
   end
   // ==========================================================
   // modulator and data pin
   logic mod_bit;
   assign mod_bit = cont_mode ? data_s : tx_bit_r;
   always_ff @(posedge clk_in or negedge rst_b_in) begin
      if (!rst_b_in) begin
         {mod_freq_hi_out, pa_on_out, data_pin_out, data_pin_oe_out} <= 4'h0;
         {op_mode_out, freq_deviation_value_out, fifo_level_out} <= 16'h0000;
      end else begin
         mod_freq_hi_out <= mod_bit;
         pa_on_out <= (mode == `DSF_MODE_TX) &&
                      (cfg_r[`DSF_REG_DMOD][`DSF_OOK_BIT] ? mod_bit : 1'b1);
         data_pin_out <= demod_s;
         data_pin_oe_out <= cont_mode & rd_mode;
         op_mode_out <= mode;
         freq_deviation_value_out <= cfg_r[`DSF_REG_FDEV];
         fifo_level_out <= level;
      end
   end
endmodule

// File: logic/dsf_host.sv
// host end: runs one config or fifo transfer per command as serial master
// assumes the device samples the link with its own clock
`include "dsf_defines.svh"
module dsf_host (
   // clock and reset
   input wire logic clk_in,
   input wire logic rst_b_in,
   // serial link
   dsf_link_if.host link,
   // command side
   input wire logic cmd_valid_in,
   input wire dsf_pkg::dsf_cmd_t cmd_kind_in,
   input wire logic [`DSF_IDX_HI:0] cmd_addr_in,
   input wire logic [7:0] cmd_data_in,
   output logic cmd_ready_out,
   output logic rsp_valid_out,
   output logic [7:0] rsp_data_out
);
   // ==========================================================
   // sdo synchroniser
   logic sdo1_r, sdo2_r;
   always_ff @(posedge clk_in or negedge rst_b_in) begin
      if (!rst_b_in) begin
         sdo1_r <= 1'b0;
         sdo2_r <= 1'b0;
      end else begin
         sdo1_r <= link.sdo;
         sdo2_r <= sdo1_r;
      end
   end

   // ==========================================================
   // half-period timer
   dsf_pkg::dsf_hst_t st_r;
   logic [7:0] cnt_r, half_r;
   logic half_end, is_cfg;
   assign half_end = (cnt_r == half_r - 8'h01);
   assign is_cfg = (cmd_kind_in == dsf_pkg::cmd_cfg_wr) || (cmd_kind_in == dsf_pkg::cmd_cfg_rd);
   always_ff @(posedge clk_in or negedge rst_b_in) begin
      if (!rst_b_in)
         cnt_r <= 8'h00;
      else if (st_r == dsf_pkg::hs_idle || half_end)
         cnt_r <= 8'h00;
      else
         cnt_r <= cnt_r + 8'h01;
   end

   // ==========================================================
   // transfer sequencer
   logic [15:0] sh_r;
   logic [4:0] nbit_r;
   logic [7:0] rx_r;
   logic sck_r, sdi_r, cfg_n_r, fifo_n_r, rsp_r;
   always_ff @(posedge clk_in or negedge rst_b_in) begin
      if (!rst_b_in) begin
         st_r <= dsf_pkg::hs_idle;
         half_r <= `DSF_CFG_HALF;
         sh_r <= 16'h0000;
         nbit_r <= 5'h00;
         rx_r <= 8'h00;
         sck_r <= 1'b0;
         sdi_r <= 1'b0;
         cfg_n_r <= 1'b1;
         fifo_n_r <= 1'b1;
         rsp_r <= 1'b0;
      end else begin
         rsp_r <= 1'b0;
         unique case (st_r)
            dsf_pkg::hs_idle: begin
               if (cmd_valid_in) begin
                  // address byte: read flag, index; then value byte
                  sh_r <= is_cfg ?
                     {cmd_kind_in == dsf_pkg::cmd_cfg_rd, 2'h0, cmd_addr_in, cmd_data_in} :
                     {cmd_data_in, 8'h00};
                  sdi_r <= is_cfg ? (cmd_kind_in == dsf_pkg::cmd_cfg_rd) : cmd_data_in[7];
                  nbit_r <= is_cfg ? 5'h10 : 5'h08;
                  half_r <= is_cfg ? `DSF_CFG_HALF : `DSF_DAT_HALF;
                  cfg_n_r <= ~is_cfg;
                  fifo_n_r <= is_cfg;
                  st_r <= dsf_pkg::hs_low;
               end
            end
            dsf_pkg::hs_low: begin
               if (half_end) begin
                  sck_r <= 1'b1;
                  rx_r <= {rx_r[6:0], sdo2_r};
                  st_r <= dsf_pkg::hs_high;
               end
            end
            dsf_pkg::hs_high: begin
               if (half_end) begin
                  sck_r <= 1'b0;
                  sh_r <= {sh_r[14:0], 1'b0};
                  sdi_r <= sh_r[14];
                  nbit_r <= nbit_r - 5'h01;
                  st_r <= (nbit_r == 5'h01) ? dsf_pkg::hs_tail : dsf_pkg::hs_low;
               end
            end
            dsf_pkg::hs_tail: begin
               if (half_end) begin
                  cfg_n_r <= 1'b1;
                  fifo_n_r <= 1'b1;
                  st_r <= dsf_pkg::hs_gap;
               end
            end
            dsf_pkg::hs_gap: begin
               if (half_end) begin
                  rsp_r <= 1'b1;
                  st_r <= dsf_pkg::hs_idle;
               end
            end
         endcase
      end
   end
   assign link.sck = sck_r;
   assign link.sdi = sdi_r;
   assign link.config_port_select_n = cfg_n_r;
   assign link.fifo_port_select_n = fifo_n_r;
   assign cmd_ready_out = (st_r == dsf_pkg::hs_idle);
   assign rsp_valid_out = rsp_r;
   assign rsp_data_out = rx_r;
endmodule

// File: verification/dsf_link_props.sv
// checker on the serial link between the host end and the device end
// assumes instantiation beside the link interface with the system clock and reset
`include "dsf_defines.svh"
module dsf_link_props (
   // clock and reset
   input wire logic clk_in,
   input wire logic rst_b_in,
   // serial link
   input wire logic sck,
   input wire logic sdi,
   input wire logic config_port_select_n,
   input wire logic fifo_port_select_n,
   input wire logic sdo,
   input wire logic sdo_oe
);
   timeunit 1ns;
   timeprecision 100ps;
   localparam int CFG_HALF = `DSF_CFG_HALF;
   localparam int DAT_HALF = `DSF_DAT_HALF;
   logic idle;
   logic [7:0] high_cnt_r;
   logic [7:0] bit_cnt_r;

   assign idle = config_port_select_n & fifo_port_select_n;

   default clocking cb @(posedge clk_in);
   endclocking
   default disable iff (!rst_b_in);

   // ==========================================================
   // helpers: sck high length, rises per selection
   always_ff @(posedge clk_in or negedge rst_b_in) begin
      if (!rst_b_in) begin
         high_cnt_r <= 8'h00;
      end else if (!sck) begin
         high_cnt_r <= 8'h00;
      end else if (high_cnt_r != 8'hff) begin
         high_cnt_r <= high_cnt_r + 8'h01;
      end
   end

   always_ff @(posedge clk_in or negedge rst_b_in) begin
      if (!rst_b_in) begin
         bit_cnt_r <= 8'h00;
      end else if (idle) begin
         bit_cnt_r <= 8'h00;
      end else if ($rose(sck)) begin
         bit_cnt_r <= bit_cnt_r + 8'h01;
      end
   end

   // ==========================================================
   // assertions
   a_sdo_released_idle: assert property (idle [*4] |-> !sdo_oe)
      else $error("sdo driven while not selected");
   a_config_drives_sdo: assert property ((!config_port_select_n) [*4] |-> sdo_oe)
      else $error("sdo not driven under config select");
   a_sdo_bus_hold: assert property (!sdo_oe && !$past(sdo_oe) |-> $stable(sdo))
      else $error("sdo moved while released");
   a_sdo_moves_low: assert property ($changed(sdo) |-> !sck)
      else $error("sdo changed while sck high");
   a_sck_idle_low: assert property (idle |-> !sck)
      else $error("sck high between transfers");
   a_sdi_steady_high: assert property (sck && $past(sck) |-> $stable(sdi))
      else $error("sdi changed while sck high");
   a_rise_selected: assert property ($rose(sck) |-> !idle)
      else $error("sck rise with no select low");
   a_cfg_half_len: assert property ($fell(sck) && !config_port_select_n |-> high_cnt_r >= CFG_HALF)
      else $error("config sck high phase too short");
   a_fifo_half_len: assert property ($fell(sck) && config_port_select_n |-> high_cnt_r >= DAT_HALF)
      else $error("fifo sck high phase too short");
   a_whole_bytes: assert property ($rose(idle) |-> bit_cnt_r[2:0] == 3'h0 && bit_cnt_r != 8'h00)
      else $error("selection ended off a byte boundary");

   c_config_transfer: cover property ($rose(idle) && bit_cnt_r == 8'h10);
   c_fifo_transfer: cover property ($fell(fifo_port_select_n) && config_port_select_n);
   c_sdo_driven: cover property ($rose(sdo_oe));
endmodule

// File: verification/dual_select_spi_fifo_port_test.sv
// bench top: host and device ends joined by the link, driven through host commands
// assumes the package, interface, design ends and checker are compiled before it
`include "dsf_defines.svh"
module dual_select_spi_fifo_port_test;
   timeunit 1ns;
   timeprecision 100ps;
   logic clk_in;
   logic rst_b_in;
   logic cmd_valid;
   dsf_pkg::dsf_cmd_t cmd_kind;
   logic [`DSF_IDX_HI:0] cmd_addr;
   logic [7:0] cmd_data;
   logic cmd_ready;
   logic rsp_valid;
   logic [7:0] rsp_data;
   logic demod_bit;
   logic data_pin;
   logic data_pin_out;
   logic data_pin_oe;
   logic mod_freq_hi;
   logic pa_on;
   logic [2:0] op_mode;
   logic [7:0] freq_dev;
   logic [`DSF_PTR_W-1:0] fifo_level;
   logic [7:0] last_rsp;
   int fails;
   int samples_checked;
   int guard;

   dsf_link_if link();
   dsf_host i_dsf_host (.clk_in(clk_in), .rst_b_in(rst_b_in), .link(link),
      .cmd_valid_in(cmd_valid), .cmd_kind_in(cmd_kind), .cmd_addr_in(cmd_addr),
      .cmd_data_in(cmd_data), .cmd_ready_out(cmd_ready), .rsp_valid_out(rsp_valid),
      .rsp_data_out(rsp_data));
   dsf_device i_dsf_device (.clk_in(clk_in), .rst_b_in(rst_b_in), .link(link),
      .demod_bit_in(demod_bit), .data_pin_in(data_pin), .data_pin_out(data_pin_out),
      .data_pin_oe_out(data_pin_oe), .mod_freq_hi_out(mod_freq_hi), .pa_on_out(pa_on),
      .op_mode_out(op_mode), .freq_deviation_value_out(freq_dev),
      .fifo_level_out(fifo_level));
   dsf_link_props i_dsf_link_props (.clk_in(clk_in), .rst_b_in(rst_b_in), .sck(link.sck),
      .sdi(link.sdi), .config_port_select_n(link.config_port_select_n),
      .fifo_port_select_n(link.fifo_port_select_n), .sdo(link.sdo), .sdo_oe(link.sdo_oe));

   // ==========================================================
   // shared tasks
   task automatic finish_test();
      if (fails == 0 && samples_checked > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask

   task automatic tick(input int n);
      repeat (n) @(posedge clk_in);
      #1;
   endtask

   task automatic step();
      tick(1);
      guard++;
      if (guard > 6000) begin
         fails++;
         finish_test();
      end
   endtask

   task automatic check(input logic [7:0] got, input logic [7:0] exp);
      samples_checked++;
      if (got !== exp) begin
         fails++;
         $display("unexpected at %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   task automatic run_cmd(input dsf_pkg::dsf_cmd_t kind, input logic [4:0] addr,
                          input logic [7:0] data);
      guard = 0;
      while (cmd_ready !== 1'b1) step();
      cmd_kind = kind;
      cmd_addr = addr;
      cmd_data = data;
      cmd_valid = 1'b1;
      tick(1);
      cmd_valid = 1'b0;
      guard = 0;
      while (rsp_valid !== 1'b1) step();
      last_rsp = rsp_data;
   endtask

   task automatic wait_cfg(input logic lvl);
      while (link.config_port_select_n !== lvl) step();
   endtask

   // ==========================================================
   // scenarios
   task automatic t_defaults();
      check(8'(op_mode), 8'h01);
      check(freq_dev, `DSF_FDEV_RST);
      check(8'(fifo_level), 8'h00);
      run_cmd(dsf_pkg::cmd_cfg_rd, `DSF_REG_DMOD, 8'h00);
      check(last_rsp, `DSF_DMOD_RST);
      run_cmd(dsf_pkg::cmd_cfg_rd, `DSF_REG_BRS, 8'h00);
      check(last_rsp, `DSF_BRS_RST);
   endtask

   task automatic t_cfg_commit();
      fork
         run_cmd(dsf_pkg::cmd_cfg_wr, `DSF_REG_FDEV, 8'ha5);
         begin
            wait_cfg(1'b0);
            wait_cfg(1'b1);
            check(freq_dev, `DSF_FDEV_RST);
         end
      join
      check(freq_dev, 8'ha5);
      run_cmd(dsf_pkg::cmd_cfg_rd, `DSF_REG_FDEV, 8'h00);
      check(last_rsp, 8'ha5);
   endtask

   task automatic t_fifo_push();
      run_cmd(dsf_pkg::cmd_fifo_wr, 5'h00, 8'h96);
      check(8'(fifo_level), 8'h01);
      run_cmd(dsf_pkg::cmd_cfg_wr, `DSF_REG_DMOD, 8'h08);
      run_cmd(dsf_pkg::cmd_fifo_wr, 5'h00, 8'h3c);
      check(8'(fifo_level), 8'h02);
   endtask

   task automatic t_tx_bits();
      logic [15:0] exp;
      exp = 16'h963c;
      run_cmd(dsf_pkg::cmd_cfg_wr, `DSF_REG_BRS, 8'h00);
      run_cmd(dsf_pkg::cmd_cfg_wr, `DSF_REG_DMOD, 8'h84);
      fork
         run_cmd(dsf_pkg::cmd_cfg_wr, `DSF_REG_GCON, 8'h80);
         begin
            while (mod_freq_hi !== 1'b1) step();
            tick(25);
            for (int i = 0; i < 16; i++) begin
               check(8'(mod_freq_hi), 8'(exp[15-i]));
               check(8'(pa_on), 8'(exp[15-i]));
               tick(50);
            end
         end
      join
      check(8'(fifo_level), 8'h00);
      run_cmd(dsf_pkg::cmd_cfg_wr, `DSF_REG_GCON, 8'h20);
   endtask

   task automatic t_continuous();
      run_cmd(dsf_pkg::cmd_cfg_wr, `DSF_REG_DMOD, 8'h00);
      run_cmd(dsf_pkg::cmd_fifo_wr, 5'h00, 8'haa);
      check(8'(fifo_level), 8'h00);
      check(8'(data_pin_oe), 8'h00);
      run_cmd(dsf_pkg::cmd_cfg_wr, `DSF_REG_GCON, 8'h60);
      demod_bit = 1'b1;
      tick(10);
      check(8'(data_pin_oe), 8'h01);
      check(8'(data_pin_out), 8'h01);
      demod_bit = 1'b0;
      tick(10);
      check(8'(data_pin_out), 8'h00);
      data_pin = 1'b1;
      tick(10);
      check(8'(mod_freq_hi), 8'h01);
      check(8'(pa_on), 8'h00);
      data_pin = 1'b0;
   endtask

   task automatic t_rx_bytes();
      demod_bit = 1'b1;
      run_cmd(dsf_pkg::cmd_cfg_wr, `DSF_REG_DMOD, 8'h04);
      guard = 0;
      while (!(fifo_level >= 5'h01)) step();
      run_cmd(dsf_pkg::cmd_fifo_rd, 5'h00, 8'h00);
      check(last_rsp, 8'hff);
      run_cmd(dsf_pkg::cmd_cfg_wr, `DSF_REG_GCON, 8'h20);
   endtask

   // ==========================================================
   // clock and main sequence
   initial begin
      clk_in = 1'b0;
      forever #2 clk_in = ~clk_in;
   end

   initial begin
      rst_b_in = 1'b0;
      cmd_valid = 1'b0;
      cmd_kind = dsf_pkg::cmd_cfg_wr;
      cmd_addr = 5'h00;
      cmd_data = 8'h00;
      demod_bit = 1'b0;
      data_pin = 1'b0;
      last_rsp = 8'h00;
      fails = 0;
      samples_checked = 0;
      guard = 0;
      tick(12);
      rst_b_in = 1'b1;
      tick(4);
      t_defaults();
      t_cfg_commit();
      t_fifo_push();
      t_tx_bits();
      t_continuous();
      t_rx_bytes();
      finish_test();
   end
endmodule
